//--- core/jtr_pkg.sv
// Constants, states and carrier types for the test data register block
package jtr_pkg;

    // Register widths and chain lengths
    localparam int unsigned ID_W   = 32;
    localparam int unsigned IR_W   = 4;
    localparam int unsigned SC_W   = 4;
    localparam int unsigned C0_LEN = 105;
    localparam int unsigned C1_LEN = 33;

    // Instruction codes
    localparam logic [3:0] INS_EXTEST = 4'h0;
    localparam logic [3:0] INS_SCAN_N = 4'h2;
    localparam logic [3:0] INS_INTEST = 4'hc;
    localparam logic [3:0] INS_IDCODE = 4'he;
    localparam logic [3:0] INS_BYPASS = 4'hf;

    // Capture patterns and reset chain
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] SC_CAPTURE = 4'h8;
    localparam logic [3:0] SC_RESET   = 4'h3;

    // Chain numbers
    localparam logic [3:0] CH_CORE     = 4'h0;
    localparam logic [3:0] CH_DEBUG    = 4'h1;
    localparam logic [3:0] CH_DBG_PROG = 4'h2;
    localparam logic [3:0] CH_EXT      = 4'h3;
    localparam logic [3:0] CH_RSV_A    = 4'h4;
    localparam logic [3:0] CH_RSV_B    = 4'h8;
    localparam logic [3:0] CH_SYS_CTRL = 4'hf;

    // Identification code, value arbitrary
    localparam logic [31:0] ID_CODE = 32'h0a5a_0001;

    // Chain 0 layout: cells 0..40 input cells, 41..104 output cells,
    // of which 41..72 are data bus cells with an update latch
    localparam logic [C0_LEN-1:0] C0_IN_MASK  = {64'h0, 41'h1ff_ffff_ffff};
    localparam logic [C0_LEN-1:0] C0_UPD_MASK = {32'h0, 32'hffff_ffff, 41'h0};
    // Chain 1: 32 data cells and one breakpoint cell, all toward the core
    localparam logic [C1_LEN-1:0] C1_IN_MASK  = {1'h1, 32'hffff_ffff};
    localparam logic [C1_LEN-1:0] C1_UPD_MASK = {1'h0, 32'h0};

    // Sixteen-state test access controller
    typedef enum logic [3:0] {
        ST_TLR, ST_RTI,
        ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } jtr_tap_state_t;

    // Strobes from the controller to one scan chain
    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
        logic tdi;
    } jtr_scan_ctl_t;

endpackage

//--- core/jtr_scan_chain.sv
// One internal scan chain: serial cells, cell muxes and optional update latches
module jtr_scan_chain
    import jtr_pkg::*;
#(
    parameter int unsigned      LEN      = 33,
    parameter logic [LEN-1:0]   UPD_MASK = '0
)
(
    input  wire logic           core_clk_i,
    input  wire logic           arst_n_i,
    input  wire jtr_scan_ctl_t  ctl_i,
    input  wire logic [LEN-1:0] norm_i,
    input  wire logic [LEN-1:0] test_en_i,
    output logic [LEN-1:0]      cell_o,
    output logic                serial_o
);

    logic [LEN-1:0] sr_q;
    logic [LEN-1:0] upd_q;
    logic [LEN-1:0] drive;

    // Capture copies each cell's normal signal, shift moves toward bit 0
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            sr_q <= '0;
        else if (ctl_i.capture)
            sr_q <= norm_i; // RULE16
        else if (ctl_i.shift)
            sr_q <= {ctl_i.tdi, sr_q[LEN-1:1]};
    end

    // Update latch, only meaningful for cells in UPD_MASK
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            upd_q <= '0;
        else if (ctl_i.update)
            upd_q <= sr_q; // RULE21
    end

    // No update stage elsewhere: those cells follow the shift directly
    assign drive = (UPD_MASK & upd_q) | (~UPD_MASK & sr_q);

    // Per-cell mux between normal path and scanned value
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cell_o <= '0;
        else
            cell_o <= (test_en_i & drive) | (~test_en_i & norm_i); // RULE17 RULE18
    end

    assign serial_o = sr_q[0];

endmodule // jtr_scan_chain

//--- core/jtr_test_regs.sv
// Test data registers, instruction path and chain routing behind the test port
//
// Contract
// [RULE1] Capture-data loads fixed 32-bit identification code
// [RULE2] Identification read routes ID register, no parallel output
// [RULE3] Instruction register 4 bits, shifts in shift-IR
// [RULE4] Capture-IR loads 0001, shifts lsb first
// [RULE5] Update-IR makes shifted value current instruction
// [RULE6] Test logic reset selects identification read
// [RULE7] Chain select register 4 bits, shifts under select
// [RULE8] Capture loads 1000, shifts lsb first
// [RULE9] Update-data makes held chain number active
// [RULE10] Chain changes only by select; reset picks 3
// [RULE11] Chain, instruction, state, clock phases driven out
// [RULE12] Chain 3 or unassigned routes external chain
// [RULE13] Outside mux steers returns by chain number
// [RULE14] Chain numbers decode to fixed functions
// [RULE15] Chain 0 is 105, chain 1 33 bits
// [RULE16] Capture copies normal signal into each cell
// [RULE17] Cell mux picks normal or serial value
// [RULE18] System passes through; internal/external test drive
// [RULE19] Outside logic tolerates outputs toggling while shifting
// [RULE20] Internal test clocks core once in idle
// [RULE21] External test: data bus updates, core unclocked
// [RULE22] Chain 1 debug follows internal test procedure
// [RULE23] Inputs sampled rising, output changes falling edge
// [RULE24] Identification read uses code 1110
// [RULE25] Chain select uses code 0010
// [RULE26] External 0000, internal 1100 place chain
// [RULE27] Standard sixteen-state controller advanced by mode select
module jtr_test_regs
    import jtr_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              test_clk_i,
    input  wire logic              test_mode_sel_i,
    input  wire logic              test_data_in_i,
    input  wire logic              test_reset_n_i,
    input  wire logic              ext_chain_serial_return_i,
    input  wire logic [C0_LEN-1:0] c0_norm_i,
    input  wire logic [C1_LEN-1:0] c1_norm_i,
    output logic                   test_data_out_o,
    output logic                   test_data_out_en_o,
    output logic                   ext_chain_serial_out_o,
    output logic [3:0]             active_chain_out_o,
    output logic [3:0]             current_instr_out_o,
    output logic [3:0]             tap_state_out_o,
    output logic                   test_clk_phase_a_o,
    output logic                   test_clk_phase_b_o,
    output logic                   core_step_o,
    output logic [C0_LEN-1:0]      c0_cell_o,
    output logic [C1_LEN-1:0]      c1_cell_o
);

    // Pin synchronisers: {clock, mode, data, reset, return}
    logic [4:0]     meta_q;
    logic [4:0]     sync_q;
    logic           tck_prev_q;
    logic           tck_s;
    logic           tms_s;
    logic           tdi_s;
    logic           trst_n_s;
    logic           ret_s;
    logic           rise;
    logic           fall;

    jtr_tap_state_t state_q;
    jtr_tap_state_t state_d;
    logic [3:0]     instr_q;
    logic [3:0]     ir_sh_q;
    logic [3:0]     chain_q;
    logic [3:0]     sc_sh_q;
    logic [ID_W-1:0] id_sh_q;
    logic           byp_q;
    logic           ext_out_q;
    logic           tdo_q;
    logic           tdo_en_q;
    logic           step_q;
    logic           ph_a_q;
    logic           ph_b_q;

    logic           test_ins;
    logic           ext_sel;
    logic           c0_sel;
    logic           c1_sel;
    logic           c0_ser;
    logic           c1_ser;
    logic           dr_bit;
    logic           cap_dr;
    logic           sh_dr;
    logic           upd_dr;
    jtr_scan_ctl_t  c0_ctl;
    jtr_scan_ctl_t  c1_ctl;
    logic [C0_LEN-1:0] c0_en;
    logic [C1_LEN-1:0] c1_en;

    // Two flops on every pin; only stage two is read
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_q <= 5'h00;
            sync_q <= 5'h00;
        end
        else
        begin
            meta_q <= {test_clk_i, test_mode_sel_i, test_data_in_i,
                       test_reset_n_i, ext_chain_serial_return_i};
            sync_q <= meta_q;
        end
    end

    assign tck_s    = sync_q[4];
    assign tms_s    = sync_q[3];
    assign tdi_s    = sync_q[2];
    assign trst_n_s = sync_q[1];
    assign ret_s    = sync_q[0];

    // Edge finder on the synchronised test clock
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            tck_prev_q <= 1'b0;
        else
            tck_prev_q <= tck_s;
    end

    // Mode and data are aligned with the clock, so sampling at rise is safe
    assign rise = tck_s & ~tck_prev_q; // RULE23
    assign fall = ~tck_s & tck_prev_q;

    // Controller next state
    always_comb
    begin
        unique case (state_q) // RULE27
            ST_TLR:    state_d = tms_s ? ST_TLR : ST_RTI;
            ST_RTI:    state_d = tms_s ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  state_d = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_d = tms_s ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_d = tms_s ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_d = tms_s ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_d = tms_s ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_d = tms_s ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: state_d = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  state_d = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_d = tms_s ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_d = tms_s ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_d = tms_s ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_d = tms_s ? ST_SEL_DR : ST_RTI;
        endcase
    end

    // Controller state; the test reset pin forces logic reset
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            state_q <= ST_TLR;
        else if (!trst_n_s)
            state_q <= ST_TLR;
        else if (rise)
            state_q <= state_d; // RULE27
    end

    // Instruction shift register
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ir_sh_q <= IR_CAPTURE;
        else if (rise && state_q == ST_CAP_IR)
            ir_sh_q <= IR_CAPTURE; // RULE4
        else if (rise && state_q == ST_SH_IR)
            ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]}; // RULE3 RULE4
    end

    // Current instruction
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            instr_q <= INS_IDCODE;
        else if (!trst_n_s || state_q == ST_TLR)
            instr_q <= INS_IDCODE; // RULE6
        else if (rise && state_q == ST_UPD_IR)
            instr_q <= ir_sh_q; // RULE5
    end

    assign cap_dr = rise && state_q == ST_CAP_DR;
    assign sh_dr  = rise && state_q == ST_SH_DR;
    assign upd_dr = rise && state_q == ST_UPD_DR;

    // Identification register; read only, never drives anything in parallel
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            id_sh_q <= '0;
        else if (cap_dr && instr_q == INS_IDCODE) // RULE24
            id_sh_q <= ID_CODE; // RULE1
        else if (sh_dr && instr_q == INS_IDCODE)
            id_sh_q <= {tdi_s, id_sh_q[ID_W-1:1]}; // RULE2
    end

    // Chain select shift register
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            sc_sh_q <= SC_CAPTURE;
        else if (cap_dr && instr_q == INS_SCAN_N) // RULE25
            sc_sh_q <= SC_CAPTURE; // RULE8
        else if (sh_dr && instr_q == INS_SCAN_N)
            sc_sh_q <= {tdi_s, sc_sh_q[SC_W-1:1]}; // RULE7 RULE8
    end

    // Active chain moves only on a chain-select update or a reset
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            chain_q <= SC_RESET; // RULE10
        else if (!trst_n_s || state_q == ST_TLR)
            chain_q <= SC_RESET; // RULE10
        else if (upd_dr && instr_q == INS_SCAN_N)
            chain_q <= sc_sh_q; // RULE9
    end

    // One-bit bypass for every other non-test instruction, and for tests of chains 2, 4, 8 and 15
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            byp_q <= 1'b0;
        else if (cap_dr)
            byp_q <= 1'b0;
        else if (sh_dr)
            byp_q <= tdi_s;
    end

    // Chain decode; 2, 4, 8 and 15 have no cells here and fall back to bypass
    assign test_ins = instr_q == INS_EXTEST || instr_q == INS_INTEST; // RULE26
    assign c0_sel   = test_ins && chain_q == CH_CORE; // RULE14
    assign c1_sel   = test_ins && chain_q == CH_DEBUG; // RULE14
    assign ext_sel  = test_ins && chain_q != CH_CORE && chain_q != CH_DEBUG
                      && chain_q != CH_DBG_PROG && chain_q != CH_RSV_A
                      && chain_q != CH_RSV_B && chain_q != CH_SYS_CTRL; // RULE12 RULE14

    // Strobes to the internal chains
    assign c0_ctl = '{capture: cap_dr & c0_sel, shift: sh_dr & c0_sel,
                      update: upd_dr & c0_sel, tdi: tdi_s};
    assign c1_ctl = '{capture: cap_dr & c1_sel, shift: sh_dr & c1_sel,
                      update: upd_dr & c1_sel, tdi: tdi_s};

    // Internal test drives core inputs, external test drives system outputs
    always_comb
    begin
        c0_en = '0;
        c1_en = '0;
        if (c0_sel && instr_q == INS_INTEST)
            c0_en = C0_IN_MASK; // RULE18 RULE20
        else if (c0_sel)
            c0_en = ~C0_IN_MASK; // RULE18 RULE21
        if (c1_sel && instr_q == INS_INTEST)
            c1_en = C1_IN_MASK; // RULE22
        else if (c1_sel)
            c1_en = ~C1_IN_MASK; // RULE22
    end

    jtr_scan_chain #(
        .LEN      (C0_LEN),
        .UPD_MASK (C0_UPD_MASK)
    ) u_chain0 ( // RULE15
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .ctl_i      (c0_ctl),
        .norm_i     (c0_norm_i),
        .test_en_i  (c0_en),
        .cell_o     (c0_cell_o),
        .serial_o   (c0_ser)
    );

    jtr_scan_chain #(
        .LEN      (C1_LEN),
        .UPD_MASK (C1_UPD_MASK)
    ) u_chain1 ( // RULE15
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .ctl_i      (c1_ctl),
        .norm_i     (c1_norm_i),
        .test_en_i  (c1_en),
        .cell_o     (c1_cell_o),
        .serial_o   (c1_ser)
    );

    // Serial feed to the external chain; outside mux picks its return
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ext_out_q <= 1'b0;
        else if (sh_dr && ext_sel)
            ext_out_q <= tdi_s; // RULE12 RULE13
    end

    // Data path mux toward test data out
    always_comb
    begin
        if (instr_q == INS_IDCODE)
            dr_bit = id_sh_q[0]; // RULE2
        else if (instr_q == INS_SCAN_N)
            dr_bit = sc_sh_q[0]; // RULE7
        else if (c0_sel)
            dr_bit = c0_ser;
        else if (c1_sel)
            dr_bit = c1_ser;
        else if (ext_sel)
            dr_bit = ret_s; // RULE12
        else
            dr_bit = byp_q;
    end

    // Output moves only on the falling test clock edge
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tdo_q    <= 1'b0;
            tdo_en_q <= 1'b0;
        end
        else if (fall)
        begin
            tdo_q    <= (state_q == ST_SH_IR) ? ir_sh_q[0] : dr_bit; // RULE23 RULE3
            tdo_en_q <= state_q == ST_SH_IR || state_q == ST_SH_DR;
        end
    end

    // Single core step from idle; never under external test
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            step_q <= 1'b0;
        else
            step_q <= rise && state_q == ST_RTI && instr_q == INS_INTEST
                      && (c0_sel || c1_sel); // RULE20 RULE21 RULE22
    end

    // Two non-overlapping phases rebuilt from the sampled clock
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ph_a_q <= 1'b0;
            ph_b_q <= 1'b0;
        end
        else
        begin
            ph_a_q <= tck_s & tck_prev_q;
            ph_b_q <= ~tck_s & ~tck_prev_q;
        end
    end

    // Status outputs for deriving external chain control
    assign active_chain_out_o     = chain_q; // RULE11
    assign current_instr_out_o    = instr_q; // RULE11
    assign tap_state_out_o        = 4'(state_q); // RULE11
    assign test_clk_phase_a_o     = ph_a_q;
    assign test_clk_phase_b_o     = ph_b_q;
    assign test_data_out_o        = tdo_q;
    assign test_data_out_en_o     = tdo_en_q;
    assign ext_chain_serial_out_o = ext_out_q;
    assign core_step_o            = step_q;

endmodule // jtr_test_regs

//--- tb/jtr_ctrl_model.sv
// Outside test controller and external chain return mux
module jtr_ctrl_model
    import jtr_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [3:0] active_chain_i,
    input  wire logic       tdo_i,
    output logic            tck_o,
    output logic            tms_o,
    output logic            tdi_o,
    output logic            trst_n_o,
    output logic            ret_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic ret_val;
    logic flip_q;

    // Pins idle, test clock stands low between frames
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        trst_n_o = 1'b1;
        ret_val = 1'b0;
    end

    // Unselected chains return a toggling value, never a stale one
    always_ff @(posedge core_clk_i or negedge arst_n_i)
        if (!arst_n_i)
            flip_q <= 1'b0;
        else
            flip_q <= ~flip_q;

    // Outside mux decoded from the active chain number
    assign ret_o = (active_chain_i == CH_EXT) ? ret_val : (active_chain_i == 4'h5) ? ~ret_val : flip_q;

    // One 80 ns test clock; pins change at the fall, out read before rise
    task automatic step(input logic m, input logic d, output logic q);
        tms_o = m;
        tdi_o = d;
        repeat (8) @(negedge core_clk_i);
        q = tdo_i;
        tck_o = 1'b1;
        repeat (8) @(negedge core_clk_i);
        tck_o = 1'b0;
    endtask

    // Data scan from idle back to idle, lsb first
    task automatic scan_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++)
            step(i == n - 1, din[i], dout[i]);
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask

    // Instruction scan from idle back to idle
    task automatic scan_ir(input logic [3:0] ins, output logic [3:0] cap);
        logic b;
        step(1'b1, 1'b0, b);
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < 4; i++)
            step(i == 3, ins[i], cap[i]);
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask

    // Logic reset by mode select, preceded by a test reset pin pulse when pin is set
    task automatic tap_reset(input logic pin);
        logic b;
        trst_n_o = !pin;
        repeat (8) @(negedge core_clk_i);
        trst_n_o = 1'b1;
        repeat (5) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
endmodule // jtr_ctrl_model

//--- tb/jtr_test_regs_props.sv
// Port assertions for the test data register block
module jtr_test_regs_props
    import jtr_pkg::*;
(
    input wire logic       core_clk_i,
    input wire logic       arst_n_i,
    input wire logic       test_clk_i,
    input wire logic       test_reset_n_i,
    input wire logic       test_data_out_o,
    input wire logic       test_data_out_en_o,
    input wire logic       ext_chain_serial_out_o,
    input wire logic [3:0] active_chain_out_o,
    input wire logic [3:0] current_instr_out_o,
    input wire logic [3:0] tap_state_out_o,
    input wire logic       test_clk_phase_a_o,
    input wire logic       test_clk_phase_b_o,
    input wire logic       core_step_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking dcb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // Serial out moves only well inside the low phase
    a_tdo_on_fall: assert property ($changed(test_data_out_o) |-> !test_clk_i && !$past(test_clk_i, 3))
        else $error("serial out moved outside low phase");
    // Phases must never overlap, external chains clock from them
    a_phase_disjoint: assert property ((test_clk_phase_a_o || test_clk_phase_b_o) |->
        (test_clk_phase_a_o ^ test_clk_phase_b_o) && test_clk_phase_a_o == $past(test_clk_i, 3))
        else $error("clock phases overlap");
    // Instruction changes only at update-IR or logic reset
    a_instr_by_update: assert property ($changed(current_instr_out_o) |->
        $past(tap_state_out_o) inside {4'hf, 4'h0} || tap_state_out_o == 4'h0)
        else $error("instruction changed outside update");
    // Chain changes only at update-DR under select, or logic reset
    a_chain_by_select: assert property ($changed(active_chain_out_o) |->
        ($past(tap_state_out_o) == 4'h8 && current_instr_out_o == INS_SCAN_N)
        || tap_state_out_o == 4'h0 || $past(tap_state_out_o) == 4'h0)
        else $error("chain changed outside select");
    // Held test reset forces the defaults
    a_test_reset_dflt: assert property (!test_reset_n_i [*4] |=> tap_state_out_o == 4'h0
        && current_instr_out_o == INS_IDCODE && active_chain_out_o == SC_RESET)
        else $error("test reset defaults missing");
    // One core step, only under internal test of chain 0 or 1
    a_step_single: assert property (core_step_o |->
        (current_instr_out_o == INS_INTEST && active_chain_out_o <= 4'h1) ##1 !core_step_o)
        else $error("core step misplaced");
    // Output enable rises only in a shift state
    a_tdo_en_shift: assert property ($rose(test_data_out_en_o) |-> tap_state_out_o inside {4'h4, 4'hb})
        else $error("output enable outside shift");
    // External chain data moves only when shifting that chain
    a_ext_out_shift: assert property ($changed(ext_chain_serial_out_o) |-> $past(tap_state_out_o) == 4'h4
        && !(active_chain_out_o inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hf}))
        else $error("external chain data moved");
endmodule // jtr_test_regs_props

//--- tb/jtr_test_regs_tb.sv
// Self-checking bench for the test data register block
module jtr_test_regs_tb
    import jtr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk = 1'b0;
    logic              arst_n = 1'b0;
    logic              tck, tms, tdi, trst_n, ret, tdo, tdo_en, ext_out, ph_a, ph_b, step_p;
    logic [C0_LEN-1:0] norm0 = '0;
    logic [C1_LEN-1:0] norm1 = '0;
    logic [C0_LEN-1:0] cell0;
    logic [C1_LEN-1:0] cell1;
    logic [3:0]        chain, instr, state, c;
    logic [127:0]      din, dout, tmp;
    integer            seed = 32'hefd18eaa;
    int                fail_count = 0;
    int                num_checks = 0;
    int                steps = 0;
    logic [3:0]        codes[5] = '{INS_EXTEST, INS_INTEST, 4'h7, INS_BYPASS, INS_IDCODE};
    logic [3:0]        byp[4] = '{CH_DBG_PROG, CH_RSV_A, CH_RSV_B, CH_SYS_CTRL};

    // Core clock, 200 MHz
    always #2.5 core_clk = ~core_clk;

    // Core step pulses seen
    always @(negedge core_clk)
        if (step_p === 1'b1)
            steps++;

    jtr_test_regs DUT (.core_clk_i(core_clk), .arst_n_i(arst_n), .test_clk_i(tck), .test_mode_sel_i(tms),
        .test_data_in_i(tdi), .test_reset_n_i(trst_n), .ext_chain_serial_return_i(ret), .c0_norm_i(norm0),
        .c1_norm_i(norm1), .test_data_out_o(tdo), .test_data_out_en_o(tdo_en), .ext_chain_serial_out_o(ext_out),
        .active_chain_out_o(chain), .current_instr_out_o(instr), .tap_state_out_o(state),
        .test_clk_phase_a_o(ph_a), .test_clk_phase_b_o(ph_b), .core_step_o(step_p), .c0_cell_o(cell0),
        .c1_cell_o(cell1));

    jtr_ctrl_model ctl (.core_clk_i(core_clk), .arst_n_i(arst_n), .active_chain_i(chain), .tdo_i(tdo),
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .ret_o(ret));

    function automatic logic [127:0] rnd();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction

    task automatic chk(input bit ok);
        num_checks++;
        if (!ok)
        begin
            fail_count++;
            $display("Error at %0t: mismatch", $time);
        end
    endtask

    task automatic final_report();
        $display("checks %0d, errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Select a chain and check the capture pattern
    task automatic sel(input logic [3:0] n);
        ctl.scan_ir(INS_SCAN_N, c);
        chk(c === IR_CAPTURE);
        ctl.scan_dr(4, {124'h0, n}, dout);
        chk(dout[3:0] === SC_CAPTURE);
        chk(chain === n);
    endtask

    // Scan a core chain past its end; check capture, length, cells, steps
    task automatic run(input logic [3:0] ch, input logic [3:0] ins, input int len, input int st);
        logic [127:0] nrm, got, msk, lm;
        sel(ch);
        ctl.scan_ir(ins, c);
        chk(chain === ch);
        tmp = rnd();
        norm0 = tmp[C0_LEN-1:0];
        norm1 = tmp[C1_LEN-1:0];
        din = rnd();
        ctl.scan_dr(len + 8, din, dout);
        nrm = (ch == CH_CORE) ? 128'(norm0) : 128'(norm1);
        got = (ch == CH_CORE) ? 128'(cell0) : 128'(cell1);
        msk = (ch == CH_CORE) ? 128'(C0_IN_MASK) : 128'(C1_IN_MASK);
        msk = (ins == INS_EXTEST) ? ~msk : msk;
        lm = ~({128{1'b1}} << len);
        chk(((dout ^ nrm) & lm) === '0);
        chk(dout[len +: 8] === din[7:0]);
        chk(got === ((((din >> 8) & lm) & msk) | (nrm & ~msk)));
        steps = 0;
        ctl.step(1'b0, 1'b0, c[0]);
        repeat (4) @(negedge core_clk);
        chk(steps == st);
    endtask

    // Hang guard, far beyond the expected run of about 65 us
    initial
    begin
        #400000;
        fail_count++;
        final_report();
    end

    // Main sequence
    initial
    begin
        repeat (12) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        chk(chain === SC_RESET && instr === INS_IDCODE && state === 4'h0);
        ctl.step(1'b0, 1'b0, c[0]);
        norm0 = C0_LEN'(rnd());
        ctl.scan_dr(32, rnd(), dout);
        chk(dout[31:0] === ID_CODE);
        chk(cell0 === norm0);
        foreach (codes[i])
        begin
            ctl.scan_ir(codes[i], c);
            chk(c === IR_CAPTURE && instr === codes[i]);
        end
        foreach (byp[i])
        begin
            sel(byp[i]);
            ctl.scan_ir(INS_INTEST, c);
            din = rnd();
            ctl.scan_dr(4, din, dout);
            chk(dout[1:0] === {din[0], 1'b0});
        end
        run(CH_CORE, INS_INTEST, C0_LEN, 1);
        run(CH_CORE, INS_EXTEST, C0_LEN, 0);
        run(CH_DEBUG, INS_INTEST, C1_LEN, 1);
        for (int k = 0; k < 4; k++)
        begin
            ctl.ret_val = k[0];
            sel(k[1] ? 4'h5 : CH_EXT);
            ctl.scan_ir(INS_EXTEST, c);
            ctl.scan_dr(8, k[0] ? '0 : '1, dout);
            chk(dout[7:1] === {7{k[0] ^ k[1]}} && ext_out === !k[0]);
        end
        ctl.tap_reset(1'b1);
        chk(instr === INS_IDCODE && chain === SC_RESET);
        sel(CH_DEBUG);
        ctl.tap_reset(1'b0);
        chk(instr === INS_IDCODE && chain === SC_RESET);
        final_report();
    end
endmodule // jtr_test_regs_tb

bind jtr_test_regs jtr_test_regs_props u_props (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .test_clk_i(test_clk_i), .test_reset_n_i(test_reset_n_i), .test_data_out_o(test_data_out_o),
    .test_data_out_en_o(test_data_out_en_o), .ext_chain_serial_out_o(ext_chain_serial_out_o),
    .active_chain_out_o(active_chain_out_o), .current_instr_out_o(current_instr_out_o),
    .tap_state_out_o(tap_state_out_o), .test_clk_phase_a_o(test_clk_phase_a_o),
    .test_clk_phase_b_o(test_clk_phase_b_o), .core_step_o(core_step_o));
